// [hw/pulse_gen_cfg.svh]
// Timing counts and field constants for the pulse generator / slip channel.
// Assumes mclk is the clock input and runs at the rate given below.
`ifndef PULSE_GEN_CFG_SVH
`define PULSE_GEN_CFG_SVH

// Clock period in nanoseconds
`define CLK_PERIOD_NS      50
// Time a single phase slip needs to settle, in nanoseconds
`define SLIP_TIME_NS       100
// Slip settle count, rounded up to whole cycles, never below one
`define SLIP_CYCLES        (((`SLIP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) > 0 ? \
                            ((`SLIP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) : 1)
// Clock input cycles from entering the start phase to the first pulse
`define START_DELAY_CYCLES 4
// Smallest divide ratio that dynamic launch supports
`define DYN_MIN_RATIO      12'h020
// Reset values
`define TIMER_RESET        12'h001
`define DIV_RESET          12'h000

`endif

// [hw/pulse_gen_pkg.sv]
// Types shared by the pulse generator channel modules.
// Assumes nothing of its surroundings.
package pulse_gen_pkg;

    // Sequencer phases for enable, reset, start, run and stop
    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_enable = 3'b001,
        st_reset  = 3'b010,
        st_start  = 3'b011,
        st_run    = 3'b100,
        st_stop   = 3'b101
    } seq_state_t;

endpackage

// [hw/slip_if.sv]
// Link between the channel sequencer and the repeated slip engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface slip_if;
    logic        single_req; // One accepted broadcast slip request
    logic        multi_req;  // Automatic slip after sync or pulse start
    logic        repeat_en;  // Repeat each slip by the programmed count
    logic [11:0] count;      // Programmed repeat count
    logic        slip_pulse; // One cycle: hold the divider for one cycle
    logic        busy;       // Slip operations still pending

    // Engine side
    modport engine (input single_req, input multi_req, input repeat_en, input count,
                    output slip_pulse, output busy);
    // Sequencer side
    modport user (output single_req, output multi_req, output repeat_en, output count,
                  input slip_pulse, input busy);
endinterface

`default_nettype wire

// [hw/ref_pulse_timer.sv]
// Free running reference pulse timer producing one tick per programmed period.
// Assumes the period input is held steady between host updates.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_gen_cfg.svh"

module ref_pulse_timer (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [11:0] ref_pulse_timer_period, // Period in clock input cycles
    output logic             tick                    // One cycle per period
);
    logic [11:0] cnt;      // Cycle position within the period
    logic [11:0] next_cnt; // Next position
    logic        next_tick;

    // Count up to the period; zero behaves like one to avoid a stuck timer
    always_comb begin
        next_tick = (cnt >= ref_pulse_timer_period);
        next_cnt  = next_tick ? `TIMER_RESET : 12'(cnt + 12'h001);
    end

    // Register only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= `TIMER_RESET;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

    // Tick never repeats back to back when the period is above one
    a_tick_spacing : assert property (@(posedge mclk) disable iff (!nrst)
        (tick && ref_pulse_timer_period > 12'h001 && $stable(ref_pulse_timer_period)) |=> !tick)
        else $error("timer ticked twice in a row");
endmodule

`default_nettype wire

// [hw/multislip_engine.sv]
// Repeated slip engine: turns slip requests into spaced one-cycle slip pulses.
// Assumes requests are one-cycle pulses from the sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_gen_cfg.svh"

module multislip_engine (
    input  wire logic mclk,
    input  wire logic nrst,
    slip_if.engine    sif
);
    localparam int SLIP_CYC = `SLIP_CYCLES;

    logic [11:0] remaining;      // Slips still to issue
    logic [11:0] next_remaining;
    logic [7:0]  gap;            // Settle time left for the last slip
    logic [7:0]  next_gap;
    logic        pulse;
    logic        next_pulse;

    // Load on request when idle, then issue one slip every settle count plus one cycles
    always_comb begin
        next_remaining = remaining;
        next_gap       = (gap != 8'h00) ? 8'(gap - 8'h01) : 8'h00;
        next_pulse     = 1'b0;
        if (remaining == 12'h000 && gap == 8'h00) begin
            // A zero count with repeat set simply issues nothing
            if (sif.multi_req || (sif.single_req && sif.repeat_en)) begin
                next_remaining = sif.count;
            end else if (sif.single_req) begin
                next_remaining = 12'h001;
            end
        end else if (remaining != 12'h000 && gap == 8'h00) begin
            next_pulse     = 1'b1;
            next_remaining = 12'(remaining - 12'h001);
            next_gap       = 8'(SLIP_CYC);
        end
    end

    // Register only; requests arriving while busy are dropped
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            remaining <= 12'h000;
            gap       <= 8'h00;
            pulse     <= 1'b0;
        end else begin
            remaining <= next_remaining;
            gap       <= next_gap;
            pulse     <= next_pulse;
        end
    end

    assign sif.slip_pulse = pulse;
    assign sif.busy       = (remaining != 12'h000) || (gap != 8'h00) || pulse;

    // Slips are spaced by the settle time
    a_slip_spacing : assert property (@(posedge mclk) disable iff (!nrst)
        sif.slip_pulse |=> !sif.slip_pulse [*2])
        else $error("slip pulses closer than settle time");
endmodule

`default_nettype wire

// [hw/sysref_pulse_gen_slip_control.sv]
// One output divider channel with its pulse generator sequencer and slip control.
// Assumes the host keeps settings legal; all inputs synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_gen_cfg.svh"

// Function
// - Buffer follows channel enable when not dynamic
// - Dynamic control powers buffer only during events
// - Idle-low select drives zero between chains when dynamic control is off
// - Idle-low clear leaves output undriven between chains
// - Repeat slip starts after sync and launch
// - Each slip event repeats the programmed count
// - Alarm shows all phase operations completed
// - Timer period set by 12-bit value
// - Sequencer enables, resets, starts, then disables dividers
// - Pulse chains measured in timer periods
// - Stream starts fixed cycles after start phase
// - Stop forces path zero straight from sequencer
// - Dynamic launch needs divide ratio above 31
// - Broadcast slips only with slip accept
// - Sync rephase with phase-align accept, and always in dynamic mode
module sysref_pulse_gen_slip_control #(
    parameter int START_DELAY = `START_DELAY_CYCLES // Cycles from start phase to first pulse
) (
    input  wire logic        mclk,                   // Clock input
    input  wire logic        nrst,                   // Asynchronous reset, active low
    input  wire logic        chan_enable,            // Main channel enable
    input  wire logic        pulse_mode,             // Start-up mode is pulse generator
    input  wire logic        dyn_buf_ctrl,           // Buffer powered only outside idle in dynamic mode
    input  wire logic        idle_low,               // Drive zero between pulse chains when dyn_buf_ctrl is low
    input  wire logic        slip_accept,            // Act on broadcast slips
    input  wire logic        sync_accept,            // Act on sync rephase
    input  wire logic        repeat_slip_en,         // Repeat slips by count
    input  wire logic [11:0] repeat_slip_count,      // Repeat count
    input  wire logic [11:0] ref_pulse_timer_period, // Timer period in cycles
    input  wire logic [11:0] divider_ratio,          // Channel divide ratio
    input  wire logic [7:0]  pulse_periods,          // Chain length in timer periods
    input  wire logic        sync_req,               // Sync request pulse
    input  wire logic        pulse_req,              // Pulse generator request pulse
    input  wire logic        spi_slip_req,           // Register slip request pulse
    input  wire logic        general_input_pin,      // Pin slip request pulse
    output logic             clk_out,                // Channel output level
    output logic             out_oe,                 // Output actively driven
    output logic             buf_en,                 // Output buffer powered
    output logic             phase_done,             // All phase operations complete
    output logic             timer_tick              // Registered timer tick
);
    import pulse_gen_pkg::*;

    // Elaboration check on the start delay
    generate
        if (START_DELAY < 1 || START_DELAY > 255) begin : g_bad_delay
            $error("START_DELAY must be 1 to 255");
        end
    endgenerate

    slip_if sif ();

    logic        tick;            // Raw timer tick
    seq_state_t  state;           // Sequencer phase
    seq_state_t  next_state;
    logic        is_pulse;        // Current sequence is a pulse chain
    logic        next_is_pulse;
    logic [7:0]  phase_cnt;       // Start delay or run period counter
    logic [7:0]  next_phase_cnt;
    logic [11:0] div_cnt;         // Divider position
    logic [11:0] next_div_cnt;
    logic        next_clk_out;
    logic        next_out_oe;
    logic        next_buf_en;
    logic        next_phase_done;
    logic        dyn_mode;        // Pulse mode with a supported ratio
    logic        div_active;      // Divider powered and counting
    logic        stream_on;       // Pulse stream released
    logic        start_done;      // Start delay elapsed this cycle
    logic        launch;          // Leaving the start phase
    logic [7:0]  run_len;         // Chain length, zero taken as one

    ref_pulse_timer u_timer (
        .mclk                   (mclk),
        .nrst                   (nrst),
        .ref_pulse_timer_period (ref_pulse_timer_period),
        .tick                   (tick)
    );

    multislip_engine u_slip (
        .mclk (mclk),
        .nrst (nrst),
        .sif  (sif)
    );

    // Small ratios cannot power cycle in time, so they run as normal mode
    assign dyn_mode   = pulse_mode && (divider_ratio >= `DYN_MIN_RATIO);
    assign start_done = (state == st_start) && (phase_cnt >= 8'(START_DELAY - 1));
    assign launch     = start_done;
    assign run_len    = (pulse_periods == 8'h00) ? 8'h01 : pulse_periods;

    // Slip request routing into the engine
    always_comb begin
        sif.single_req = slip_accept && (spi_slip_req || general_input_pin);
        sif.multi_req  = slip_accept && repeat_slip_en && launch;
        sif.repeat_en  = repeat_slip_en;
        sif.count      = repeat_slip_count;
    end

    // Sequencer next state; phases advance on timer ticks except idle and start
    always_comb begin
        next_state     = state;
        next_is_pulse  = is_pulse;
        next_phase_cnt = phase_cnt;
        case (state)
            st_idle: begin
                // Pulse request wins over a simultaneous sync
                if (pulse_req || sync_req) begin
                    next_state    = st_enable;
                    next_is_pulse = pulse_req;
                end
            end
            st_enable: begin
                if (tick) begin
                    next_state = st_reset;
                end
            end
            st_reset: begin
                if (tick) begin
                    next_state     = st_start;
                    next_phase_cnt = 8'h00;
                end
            end
            st_start: begin
                // Fixed delay in clock input cycles, not timer periods
                if (start_done) begin
                    next_state     = is_pulse ? st_run : st_idle;
                    next_phase_cnt = 8'h00;
                end else begin
                    next_phase_cnt = 8'(phase_cnt + 8'h01);
                end
            end
            st_run: begin
                if (tick) begin
                    if (phase_cnt >= 8'(run_len - 8'h01)) begin
                        next_state = st_stop;
                    end else begin
                        next_phase_cnt = 8'(phase_cnt + 8'h01);
                    end
                end
            end
            st_stop: begin
                if (tick) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state     <= st_idle;
            is_pulse  <= 1'b0;
            phase_cnt <= 8'h00;
        end else begin
            state     <= next_state;
            is_pulse  <= next_is_pulse;
            phase_cnt <= next_phase_cnt;
        end
    end

    // Divider power and pulse release; the stop gate is plain logic on state
    always_comb begin
        div_active = chan_enable &&
                     (!dyn_mode || (state != st_idle && state != st_stop));
        stream_on  = !dyn_mode || (state == st_run) || start_done;
    end

    // Divider count with rephase and slip hold
    always_comb begin
        if (!div_active) begin
            next_div_cnt = `DIV_RESET;
        end else if (state == st_reset && (sync_accept || dyn_mode)) begin
            next_div_cnt = `DIV_RESET;
        end else if (sif.slip_pulse) begin
            // Holding one cycle shifts phase by one clock input cycle
            next_div_cnt = div_cnt;
        end else if (div_cnt >= 12'(divider_ratio - 12'h001)) begin
            next_div_cnt = `DIV_RESET;
        end else begin
            next_div_cnt = 12'(div_cnt + 12'h001);
        end
    end

    // Output stage; no extra retime stage after the stop gate
    always_comb begin
        next_clk_out = div_active && stream_on && (div_cnt < (divider_ratio >> 1));
        if (dyn_buf_ctrl && dyn_mode) begin
            next_buf_en = chan_enable && (state != st_idle);
        end else begin
            next_buf_en = chan_enable;
        end
        // Between chains drive zero only when idle-low is chosen
        next_out_oe = next_buf_en && (!dyn_mode || stream_on || idle_low);
        // Done only when the engine is empty and no slip is being requested
        next_phase_done = !sif.busy && (state == st_idle) &&
                          !sif.single_req && !sif.multi_req;
    end

    // Divider and output registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_cnt    <= `DIV_RESET;
            clk_out    <= 1'b0;
            out_oe     <= 1'b0;
            buf_en     <= 1'b0;
            phase_done <= 1'b0;
            timer_tick <= 1'b0;
        end else begin
            div_cnt    <= next_div_cnt;
            clk_out    <= next_clk_out;
            out_oe     <= next_out_oe;
            buf_en     <= next_buf_en;
            phase_done <= next_phase_done;
            timer_tick <= tick;
        end
    end

    // Steps of the sequence
    sequence s_enter_start;
        (state == st_reset) ##1 (state == st_start);
    endsequence

    a_buf_follows_en : assert property (@(posedge mclk) disable iff (!nrst)
        !dyn_buf_ctrl |=> (buf_en == $past(chan_enable)))
        else $error("buffer enable does not follow channel enable");

    a_buf_gated_idle : assert property (@(posedge mclk) disable iff (!nrst)
        (dyn_buf_ctrl && dyn_mode && state == st_idle) |=> !buf_en)
        else $error("buffer powered outside pulse event");

    a_idle_low_drive : assert property (@(posedge mclk) disable iff (!nrst)
        (chan_enable && dyn_mode && !dyn_buf_ctrl && idle_low && state == st_idle)
        |=> (out_oe && !clk_out))
        else $error("idle output not held at zero");

    a_idle_float : assert property (@(posedge mclk) disable iff (!nrst)
        (dyn_mode && !idle_low && state == st_idle) |=> !out_oe)
        else $error("idle output driven while float selected");

    a_auto_slip : assert property (@(posedge mclk) disable iff (!nrst)
        (launch && slip_accept && repeat_slip_en && repeat_slip_count != 12'h000 && !sif.busy)
        |-> ##[1:2] sif.busy)
        else $error("no multislip after launch");

    a_alarm_clear : assert property (@(posedge mclk) disable iff (!nrst)
        phase_done |-> $past(!sif.busy && state == st_idle))
        else $error("alarm raised with phase work pending");

    a_seq_order : assert property (@(posedge mclk) disable iff (!nrst)
        (state == st_reset) |-> ($past(state) == st_reset || $past(state) == st_enable))
        else $error("reset phase entered out of order");

    // Written for the default start delay of four cycles
    a_start_delay : assert property (@(posedge mclk) disable iff (!nrst)
        s_enter_start |-> (state == st_start) [*4] ##1 (state != st_start))
        else $error("start phase length wrong");

    a_stop_zero : assert property (@(posedge mclk) disable iff (!nrst)
        (dyn_mode && state == st_stop) |=> !clk_out)
        else $error("pulse stream not stopped");

    a_slip_gate : assert property (@(posedge mclk) disable iff (!nrst)
        (!slip_accept) |-> (!sif.single_req && !sif.multi_req))
        else $error("slip taken without slip accept");

    // Further guards on the chain timing, the idle hold, the divider phase and the buffer power
    a_run_on_tick : assert property (@(posedge mclk) disable iff (!nrst)
        (state == st_run && !tick) |=> (state == st_run))
        else $error("run phase ended between timer ticks");

    a_idle_holds : assert property (@(posedge mclk) disable iff (!nrst)
        (state == st_idle && !pulse_req && !sync_req) |=> (state == st_idle))
        else $error("sequencer left idle without a request");

    a_sync_rephase : assert property (@(posedge mclk) disable iff (!nrst)
        (state == st_reset && div_active && sync_accept) |=> (div_cnt == `DIV_RESET))
        else $error("divider not rephased in reset phase");

    a_slip_holds : assert property (@(posedge mclk) disable iff (!nrst)
        (sif.slip_pulse && div_active && state != st_reset) |=> (div_cnt == $past(div_cnt)))
        else $error("slip did not hold the divider");

    a_buf_on_event : assert property (@(posedge mclk) disable iff (!nrst)
        (dyn_buf_ctrl && dyn_mode && chan_enable && state == st_run) |=> buf_en)
        else $error("buffer off during pulse event");
endmodule

`default_nettype wire

// [verification/host_model.sv]
// Host side model: holds the channel settings a configuring host would program.
// Assumes the bench selects chain length and slip count with two level inputs.
`timescale 1ns/100ps
`default_nettype none

module host_model (
    input  wire logic        long_chain,             // Three timer periods instead of one
    input  wire logic        many_slips,             // Three repeats instead of one
    output logic      [11:0] ref_pulse_timer_period, // Timer period in cycles
    output logic      [11:0] divider_ratio,          // Channel divide ratio
    output logic      [11:0] repeat_slip_count,      // Repeat count
    output logic      [7:0]  pulse_periods           // Chain length in timer periods
);
    // 32 cycles is 625 kHz and equals the divider period, so it is a submultiple
    assign ref_pulse_timer_period = 12'h020;
    // Ratio 32 is the smallest one dynamic launch accepts; no phase offset is applied
    assign divider_ratio = 12'h020;
    // The clock input is far below 3 GHz, so no extra offset is needed
    assign pulse_periods = long_chain ? 8'h03 : 8'h01;
    // Never zero, so repeat enable stays legal at all times
    assign repeat_slip_count = many_slips ? 12'h003 : 12'h001;
endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for one pulse generator and slip channel.
// Assumes the design files, the host model and the timing header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_gen_cfg.svh"

module tb_top;
    logic        mclk = 1'b0;   // Clock input, 50 ns
    logic        nrst = 1'b0;   // Reset, active low
    logic        chan_enable, pulse_mode, dyn_buf_ctrl, idle_low;
    logic        slip_accept, sync_accept, repeat_slip_en;
    logic        long_chain, many_slips; // Host model selections
    logic [3:0]  req;           // Sync, pulse, register slip, pin slip
    logic [11:0] period, ratio, count;
    logic [7:0]  periods;
    logic        clk_out, out_oe, buf_en, phase_done, timer_tick;
    logic        saw_hi = 1'b0; // Output went high inside a chain
    logic [15:0] n1, n3;
    int          errors = 0;
    int          checks = 0;
    int          cyc = 0;

    always #25 mclk = ~mclk;

    host_model host (.long_chain(long_chain), .many_slips(many_slips), .ref_pulse_timer_period(period),
        .divider_ratio(ratio), .repeat_slip_count(count), .pulse_periods(periods));

    sysref_pulse_gen_slip_control dut (.mclk(mclk), .nrst(nrst), .chan_enable(chan_enable),
        .pulse_mode(pulse_mode), .dyn_buf_ctrl(dyn_buf_ctrl), .idle_low(idle_low),
        .slip_accept(slip_accept), .sync_accept(sync_accept), .repeat_slip_en(repeat_slip_en),
        .repeat_slip_count(count), .ref_pulse_timer_period(period), .divider_ratio(ratio),
        .pulse_periods(periods), .sync_req(req[0]), .pulse_req(req[1]), .spi_slip_req(req[2]),
        .general_input_pin(req[3]), .clk_out(clk_out), .out_oe(out_oe), .buf_en(buf_en),
        .phase_done(phase_done), .timer_tick(timer_tick));

    // Remember any high output level while the buffer is powered; a pulse request clears it
    always @(posedge mclk) begin
        if (req[1] === 1'b1) begin
            saw_hi <= 1'b0;
        end else if (buf_en === 1'b1 && clk_out === 1'b1) begin
            saw_hi <= 1'b1;
        end
    end

    // Cut a hang short; the whole run needs well under 5000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle request pulse, raised and lowered on falling edges
    task automatic pulse(input int w);
        // Chains start a fixed distance after a timer tick so their lengths compare
        while (w < 2 && timer_tick !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        req[w] = 1'b1;
        @(negedge mclk);
        req = 4'h0;
    endtask

    // Length of the next active stretch of buf_en or of pending phase work
    task automatic meas(input logic use_buf, output logic [15:0] n);
        int k;
        k = 0;
        n = 16'h0000;
        while (((use_buf ? buf_en : !phase_done) !== 1'b1) && k < 100) begin
            @(posedge mclk);
            #1;
            k++;
        end
        while (((use_buf ? buf_en : !phase_done) === 1'b1) && n < 16'h0fff) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // Hand back on a falling edge so the next stimulus is driven there
        @(negedge mclk);
    endtask

    initial begin
        {chan_enable, pulse_mode, dyn_buf_ctrl, idle_low} = 4'h0;
        {slip_accept, sync_accept, repeat_slip_en, long_chain, many_slips} = 5'h00;
        req = 4'h0;
        repeat (10) @(negedge mclk);
        chk("outputs in reset", {clk_out, out_oe, buf_en, phase_done, timer_tick}, 16'h0000);
        nrst = 1'b1;
        // Buffer power follows the channel enable in both modes
        for (int m = 0; m < 4; m++) begin
            pulse_mode = m[1];
            chan_enable = m[0];
            repeat (2) @(negedge mclk);
            chk("buf_en", buf_en, m[0]);
        end
        // Tick spacing equals the programmed period
        meas(1'b0, n1);
        n1 = 16'h0000;
        while (timer_tick !== 1'b1 && n1 < 100) @(negedge mclk) n1++;
        n1 = 16'h0000;
        do @(negedge mclk) n1++; while (timer_tick !== 1'b1 && n1 < 100);
        chk("tick spacing", n1, {4'h0, period});
        // Idle level with the buffer left on between chains
        for (int i = 0; i < 2; i++) begin
            idle_low = i[0];
            repeat (2) @(negedge mclk);
            chk("out_oe idle", out_oe, i[0]);
            if (i == 1) chk("clk_out idle", clk_out, 16'h0000);
        end
        // Slip ignored without slip accept
        pulse(2);
        repeat (2) @(negedge mclk);
        chk("phase_done refused", phase_done, 16'h0001);
        // One slip from the register, then three repeated slips from the pin
        slip_accept = 1'b1;
        pulse(2);
        meas(1'b0, n1);
        chk("phase_done back", phase_done, 16'h0001);
        repeat_slip_en = 1'b1;
        many_slips = 1'b1;
        pulse(3);
        meas(1'b0, n3);
        chk("slip repeat time", n3 - n1, 16'(2 * (`SLIP_CYCLES + 1)));
        // Repeat stays on so every launch below also starts a multislip
        // Dynamic buffer: off when idle, on through a chain measured in timer periods
        dyn_buf_ctrl = 1'b1;
        repeat (2) @(negedge mclk);
        chk("buf_en dyn idle", buf_en, 16'h0000);
        // A sync sequence ends after its start phase, a pulse chain runs and stops
        pulse(0);
        meas(1'b1, n3);
        pulse(1);
        meas(1'b1, n1);
        chk("sync length", n1 - n3, 16'({3'h0, period, 1'b0} - `START_DELAY_CYCLES));
        chk("chain output", saw_hi, 16'h0001);
        chk("clk_out after stop", clk_out, 16'h0000);
        long_chain = 1'b1;
        repeat (40) @(negedge mclk);
        pulse(1);
        meas(1'b1, n3);
        chk("chain length", n3 - n1, {3'h0, period, 1'b0});
        chk("phase_done end", phase_done, 16'h0001);
        conclude();
    end
endmodule

`default_nettype wire
